// >>> relay_port.sv
// serial parameter and event port of the protection relay, reached over APB
`timescale 1ns/10ps

// Function
// - event store holds up to sixty events
// - read command delivers up to five events, never again by read
// - re-read command returns the last delivered batch, repeatable
// - each record carries time stamp, channel number and event code
// - status reads 0 normal, 1 auto reset, 2 overflow, 3 both
// - writing zero to status clears it until a new condition
// - millisecond time counter 0 to 59.999 s, readable and writable
// - station address readable and writable, range 1 to 254
// - password change or close accepted only while access is open
// - self-supervision write 1 raises output and fault indicator, 0 resets
// - LED test pattern accepted only while access is open
// - out-of-range settings are discarded, old value kept
module relay_port
#(
  parameter int unsigned TICK_CYCLES = relay_pkg::MS_CYCLES
)
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  // register bus
  input  wire relay_pkg::apb_req_t  apb_req,
  output relay_pkg::apb_rsp_t       apb_rsp,
  // event source and module supervision
  input  wire logic                 evt_valid,
  input  wire logic [2:0]           evt_chan,
  input  wire logic [7:0]           evt_code,
  input  wire logic                 auto_reset_seen,
  // indicators
  output logic                      self_sup_out,
  output logic                      internal_fault_indicator,
  output logic [4:0]                led_pattern,
  output logic [7:0]                station_addr,
  output logic                      irq
);
  import relay_pkg::*;

  localparam int unsigned CW = $clog2(EVT_DEPTH+1);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  typedef enum {FILL_IDLE, FILL_RUN} fill_st_t;

  apb_rsp_t     rsp_r, rsp_nxt;
  logic         setup, wr_acc;
  logic [7:0]   a;
  logic [31:0]  d;
  logic         fill_busy;

  assign a      = apb_req.paddr;
  assign d      = apb_req.pwdata;
  // a request stays pending through its access cycles until it is answered,
  // so a transfer that meets a running batch fill is served late, not lost
  assign setup  = apb_req.psel && !rsp_r.pready;
  // writes take effect only on the completing access edge
  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite && rsp_r.pready;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  logic [1:0]         stat_r, stat_nxt;
  logic [7:0]         addr_r, addr_nxt;
  logic [9:0]         pwd_r, pwd_nxt;
  logic               open_r, open_nxt;
  logic               sup_r, sup_nxt;
  logic [4:0]         led_r, led_nxt;
  logic [IRQ_W-1:0]   ist_r, ist_nxt, imask_r, imask_nxt;
  logic               irq_r, irq_nxt;
  logic               reject;

  // ----------------------------------------------------------------
  // event store, batch window and time base
  // ----------------------------------------------------------------
  evt_rec_t           win_r [EVT_BATCH];
  evt_rec_t           win_nxt [EVT_BATCH];
  logic [2:0]         wcnt_r, wcnt_nxt;
  fill_st_t           fst_r, fst_nxt;
  evt_rec_t           head, new_rec;
  logic [CW-1:0]      fill_lvl;
  logic               st_full, st_empty, pop;
  logic [15:0]        ms_now;
  logic               time_load;

  assign new_rec   = '{stamp: ms_now, chan: evt_chan, code: evt_code};
  assign time_load = wr_acc && a == OFF_TIME && d <= TIME_MAX;
  assign fill_busy = (fst_r == FILL_RUN);
  assign pop       = fill_busy && !st_empty && wcnt_r < 3'(EVT_BATCH);

  evt_store #(.DEPTH(EVT_DEPTH)) u_store
  (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .push      (evt_valid),
    .push_data (new_rec),
    .pop       (pop),
    .head      (head),
    .count     (fill_lvl),
    .full      (st_full),
    .empty     (st_empty)
  );

  ms_counter #(.TICK_CYCLES(TICK_CYCLES)) u_time
  (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .load     (time_load),
    .load_val (d[15:0]),
    .ms_r     (ms_now)
  );

  // ----------------------------------------------------------------
  // batch fill: read command moves up to five records out of the store
  // ----------------------------------------------------------------
  always_comb
  begin
    fst_nxt  = fst_r;
    wcnt_nxt = wcnt_r;
    for (int i = 0; i < EVT_BATCH; i++)
      win_nxt[i] = win_r[i];
    case (fst_r)
      FILL_IDLE:
      begin
        if (wr_acc && a == OFF_EVT_CMD && d == CMD_EVT_READ)
        begin
          wcnt_nxt = '0;
          fst_nxt  = FILL_RUN;
        end
        // re-read leaves the window untouched so it is served again
      end
      FILL_RUN:
      begin
        if (pop)
        begin
          win_nxt[wcnt_r] = head;
          wcnt_nxt        = 3'(wcnt_r + 1'b1);
        end
        else
          fst_nxt = FILL_IDLE;
      end
      default: fst_nxt = FILL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      fst_r  <= FILL_IDLE;
      wcnt_r <= '0;
      for (int i = 0; i < EVT_BATCH; i++)
        win_r[i] <= '0;
    end
    else
    begin
      fst_r  <= fst_nxt;
      wcnt_r <= wcnt_nxt;
      for (int i = 0; i < EVT_BATCH; i++)
        win_r[i] <= win_nxt[i];
    end
  end

  // ----------------------------------------------------------------
  // settings, status and interrupts
  // ----------------------------------------------------------------
  always_comb
  begin
    stat_nxt  = stat_r;
    addr_nxt  = addr_r;
    pwd_nxt   = pwd_r;
    open_nxt  = open_r;
    sup_nxt   = sup_r;
    led_nxt   = led_r;
    imask_nxt = imask_r;
    ist_nxt   = ist_r;
    reject    = 1'b0;
    if (wr_acc)
    begin
      case (a)
        OFF_STATUS:
          if (d == 32'h0000_0000) stat_nxt = 2'h0;
        OFF_TIME:
          reject = (d > TIME_MAX);
        OFF_ADDR:
          if (d >= ADDR_MIN && d <= ADDR_MAX) addr_nxt = d[7:0];
          else reject = 1'b1;
        OFF_PWD_OPEN:
          if (d >= PWD_MIN && d <= PWD_MAX && d[9:0] == pwd_r)
            open_nxt = 1'b1;
          else reject = 1'b1;
        OFF_PWD_CHG:
          if (!open_r || d > PWD_MAX) reject = 1'b1;
          else if (d == 32'h0000_0000) open_nxt = 1'b0;
          else pwd_nxt = d[9:0];
        OFF_SELFSUP:
          if (d == 32'h0000_0001) sup_nxt = 1'b1;
          else if (d == 32'h0000_0000) sup_nxt = 1'b0;
          else reject = 1'b1;
        OFF_LEDTEST:
          if (open_r && d <= LED_MAX) led_nxt = d[4:0];
          else reject = 1'b1;
        OFF_IRQ_STAT:
          ist_nxt = ist_r & ~d[IRQ_W-1:0];
        OFF_IRQ_MASK:
          imask_nxt = d[IRQ_W-1:0];
        default: ;
      endcase
    end
    // hardware sets after the software clear, so a coincident event is kept
    if (auto_reset_seen)
      stat_nxt[STAT_AUTORST] = 1'b1;
    if (evt_valid && st_full)
      stat_nxt[STAT_OVERFLOW] = 1'b1;
    ist_nxt[IRQ_NEW_EVT] = ist_nxt[IRQ_NEW_EVT] | (evt_valid && !st_full);
    ist_nxt[IRQ_OVF]     = ist_nxt[IRQ_OVF] | (evt_valid && st_full);
    ist_nxt[IRQ_REJECT]  = ist_nxt[IRQ_REJECT] | reject;
    ist_nxt[IRQ_AUTORST] = ist_nxt[IRQ_AUTORST] | auto_reset_seen;
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      stat_r  <= 2'h0;
      addr_r  <= ADDR_RST;
      pwd_r   <= PWD_RST;
      open_r  <= 1'b0;
      sup_r   <= 1'b0;
      led_r   <= 5'h00;
      ist_r   <= '0;
      imask_r <= '0;
      irq_r   <= 1'b0;
    end
    else
    begin
      stat_r  <= stat_nxt;
      addr_r  <= addr_nxt;
      pwd_r   <= pwd_nxt;
      open_r  <= open_nxt;
      sup_r   <= sup_nxt;
      led_r   <= led_nxt;
      ist_r   <= ist_nxt;
      imask_r <= imask_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bus answer: ready in the first access cycle, held off while filling
  // ----------------------------------------------------------------
  always_comb
  begin
    rsp_nxt = '0;
    if (setup && !fill_busy && fst_nxt == FILL_IDLE)
    begin
      rsp_nxt.pready = 1'b1;
      case (a)
        OFF_STATUS:   rsp_nxt.prdata = {30'h0, stat_r};
        OFF_TIME:     rsp_nxt.prdata = {16'h0, ms_now};
        OFF_ADDR:     rsp_nxt.prdata = {24'h0, addr_r};
        OFF_SELFSUP:  rsp_nxt.prdata = {31'h0, sup_r};
        OFF_LEDTEST:  rsp_nxt.prdata = {27'h0, led_r};
        OFF_EVT_CNT:  rsp_nxt.prdata = {16'h0, 8'(fill_lvl), 5'h0, wcnt_r};
        OFF_IRQ_STAT: rsp_nxt.prdata = {28'h0, ist_r};
        OFF_IRQ_MASK: rsp_nxt.prdata = {28'h0, imask_r};
        OFF_PWD_OPEN, OFF_PWD_CHG, OFF_EVT_CMD: rsp_nxt.prdata = '0;
        default:      rsp_nxt.pslverr = 1'b1;
      endcase
      for (int i = 0; i < EVT_BATCH; i++)
        if (a == 8'(OFF_EVT_WIN + 8'(4 * i)))
        begin
          rsp_nxt.pslverr = 1'b0;
          // slots past the batch read zero, the window repeats on re-read
          rsp_nxt.prdata  = (3'(i) < wcnt_r) ? {5'h0, win_r[i]} : '0;
        end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rsp_r <= '0;
    else
      rsp_r <= rsp_nxt;
  end

  assign apb_rsp                  = rsp_r;
  assign self_sup_out             = sup_r;
  assign internal_fault_indicator = sup_r;
  assign led_pattern              = led_r;
  assign station_addr             = addr_r;
  assign irq                      = irq_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_read_cmd;
    fst_r == FILL_IDLE && wr_acc && a == OFF_EVT_CMD && d == CMD_EVT_READ;
  endsequence
  sequence s_fill_end;
    fst_r == FILL_IDLE && wcnt_r <= 3'(EVT_BATCH);
  endsequence

  a_batch_bounded : assert property (s_read_cmd |=> ##[1:6] s_fill_end)
    else $error("event batch fill did not end within five moves");
  a_reread_stable : assert property (
    fst_r == FILL_IDLE && wr_acc && a == OFF_EVT_CMD && d == CMD_EVT_REREAD
    |=> wcnt_r == $past(wcnt_r) && win_r[0] == $past(win_r[0]))
    else $error("re-read changed the delivered batch");
  a_ovf_flag : assert property (evt_valid && st_full |=> stat_r[STAT_OVERFLOW])
    else $error("overflow not flagged on full store");
  a_status_clear : assert property (
    wr_acc && a == OFF_STATUS && d == 32'h0 && !auto_reset_seen && !evt_valid
    |=> stat_r == 2'h0)
    else $error("status not cleared by zero write");
  a_addr_range : assert property (addr_r >= 8'h01 && addr_r <= 8'hFE)
    else $error("station address out of range");
  a_pwd_guard : assert property (wr_acc && a == OFF_PWD_CHG && !open_r
    |=> pwd_r == $past(pwd_r) && !open_r)
    else $error("password changed while access closed");
  a_led_guard : assert property (wr_acc && a == OFF_LEDTEST && !open_r
    |=> led_r == $past(led_r))
    else $error("led test accepted while access closed");
  a_selfsup_on : assert property (wr_acc && a == OFF_SELFSUP && d == 32'h1
    |=> self_sup_out && internal_fault_indicator)
    else $error("self-supervision output not raised");
  a_reject_keep : assert property (wr_acc && a == OFF_ADDR && d > ADDR_MAX
    |=> addr_r == $past(addr_r) ##1 ist_r[IRQ_REJECT])
    else $error("out-of-range address not discarded");
endmodule

// >>> relay_pkg.sv
// shared constants, record layout and bus carriers for the relay serial parameter port
package relay_pkg;

  // ----------------------------------------------------------------
  // event store shape
  // ----------------------------------------------------------------
  localparam int unsigned EVT_DEPTH   = 60;
  localparam int unsigned EVT_BATCH   = 5;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_STATUS   = 8'h00;
  localparam logic [7:0]  OFF_TIME     = 8'h04;
  localparam logic [7:0]  OFF_ADDR     = 8'h08;
  localparam logic [7:0]  OFF_PWD_OPEN = 8'h0C;
  localparam logic [7:0]  OFF_PWD_CHG  = 8'h10;
  localparam logic [7:0]  OFF_SELFSUP  = 8'h14;
  localparam logic [7:0]  OFF_LEDTEST  = 8'h18;
  localparam logic [7:0]  OFF_EVT_CMD  = 8'h1C;
  localparam logic [7:0]  OFF_EVT_CNT  = 8'h20;
  localparam logic [7:0]  OFF_EVT_WIN  = 8'h24;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h38;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h3C;

  // ----------------------------------------------------------------
  // command codes, ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CMD_EVT_READ   = 32'h0000_0001;
  localparam logic [31:0] CMD_EVT_REREAD = 32'h0000_0002;
  localparam logic [31:0] ADDR_MIN       = 32'h0000_0001;
  localparam logic [31:0] ADDR_MAX       = 32'h0000_00FE;
  localparam logic [31:0] PWD_MIN        = 32'h0000_0001;
  localparam logic [31:0] PWD_MAX        = 32'h0000_03E7;
  localparam logic [31:0] LED_MAX        = 32'h0000_001C;
  localparam logic [31:0] TIME_MAX       = 32'h0000_EA5F;
  localparam logic [7:0]  ADDR_RST       = 8'h01;
  localparam logic [9:0]  PWD_RST        = 10'h001;
  localparam int unsigned STAT_AUTORST   = 0;
  localparam int unsigned STAT_OVERFLOW  = 1;

  // ----------------------------------------------------------------
  // interrupt bit positions
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_NEW_EVT = 0;
  localparam int unsigned IRQ_OVF     = 1;
  localparam int unsigned IRQ_REJECT  = 2;
  localparam int unsigned IRQ_AUTORST = 3;
  localparam int unsigned IRQ_W       = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] stamp;
    logic [2:0]  chan;
    logic [7:0]  code;
  } evt_rec_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

// >>> evt_store.sv
// first-in first-out store for time-stamped event records
`timescale 1ns/10ps
module evt_store
#(
  parameter int unsigned DEPTH = 60
)
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  // fill side
  input  wire logic                      push,
  input  wire relay_pkg::evt_rec_t       push_data,
  // drain side
  input  wire logic                      pop,
  output relay_pkg::evt_rec_t            head,
  // state
  output logic [$clog2(DEPTH+1)-1:0]     count,
  output logic                           full,
  output logic                           empty
);
  import relay_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  initial
  begin
    if (DEPTH < 2) $error("evt_store depth too small");
  end

  evt_rec_t        mem [DEPTH];
  logic [PW-1:0]   wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  logic            do_push, do_pop;

  assign full    = (cnt_r == CW'(DEPTH));
  assign empty   = (cnt_r == '0);
  assign count   = cnt_r;
  assign head    = mem[rp_r];
  // a push into a full store is dropped, the caller flags overflow
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;

  always_comb
  begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (do_push)
      wp_nxt = (wp_r == PW'(DEPTH-1)) ? '0 : PW'(wp_r + 1'b1);
    if (do_pop)
      rp_nxt = (rp_r == PW'(DEPTH-1)) ? '0 : PW'(rp_r + 1'b1);
    if (do_push && !do_pop)
      cnt_nxt = CW'(cnt_r + 1'b1);
    else if (do_pop && !do_push)
      cnt_nxt = CW'(cnt_r - 1'b1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (do_push)
      mem[wp_r] <= push_data;
  end

  a_store_fill_cap : assert property (@(posedge sys_clk) disable iff (srst)
    full && push && !pop |=> cnt_r == CW'(DEPTH))
    else $error("store count moved past capacity");
  a_store_fifo : assert property (@(posedge sys_clk) disable iff (srst)
    empty && push |=> head == $past(push_data))
    else $error("oldest record is not at the head");
endmodule

// >>> ms_counter.sv
// millisecond time counter over one minute with load port
`timescale 1ns/10ps
module ms_counter
#(
  parameter int unsigned TICK_CYCLES = 20000
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // load
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  // count
  output logic [15:0]      ms_r
);
  import relay_pkg::*;

  initial
  begin
    if (TICK_CYCLES < 1) $error("ms_counter tick too short");
  end

  logic [31:0] div_r, div_nxt;
  logic [15:0] ms_nxt;
  logic        tick;

  // one-cycle enable every millisecond
  assign tick = (div_r == 32'(TICK_CYCLES - 1));

  always_comb
  begin
    div_nxt = tick ? '0 : div_r + 32'h0000_0001;
    ms_nxt  = ms_r;
    if (load)
    begin
      ms_nxt  = load_val;
      div_nxt = '0;
    end
    else if (tick)
      ms_nxt = (ms_r == TIME_MAX[15:0]) ? '0 : 16'(ms_r + 1'b1);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      div_r <= '0;
      ms_r  <= '0;
    end
    else
    begin
      div_r <= div_nxt;
      ms_r  <= ms_nxt;
    end
  end

  a_time_in_range : assert property (@(posedge sys_clk) disable iff (srst)
    ms_r <= TIME_MAX[15:0])
    else $error("time counter left one-minute range");
  a_time_wrap : assert property (@(posedge sys_clk) disable iff (srst)
    tick && !load && ms_r == TIME_MAX[15:0] |=> ms_r == 16'h0000)
    else $error("time counter did not wrap to zero");
endmodule

// >>> remote_host.sv
// remote communicator model: APB master issuing coded parameter transfers
`timescale 1ns/10ps
module remote_host
  import relay_pkg::*;
(
  // clock
  input  wire logic     sys_clk,
  // register bus
  output apb_req_t      apb_req,
  input  wire apb_rsp_t apb_rsp
);
  initial apb_req = '0;
  // request held until pready seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    // no cycle count assumed here, only the bench timeout ends a wait
    do
    begin
      @(posedge sys_clk);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    // released data is inverted so stale values never look valid
    apb_req <= '{1'b0, 1'b0, w, a, ~d};
    // one idle edge keeps the release apart from the next setup
    @(posedge sys_clk);
  endtask
endmodule

// >>> relay_port_tb.sv
// self-checking bench for the relay serial parameter port
`timescale 1ns/10ps
module relay_port_tb;
  import relay_pkg::*;
  logic        sys_clk;
  logic        srst;
  apb_req_t    apb_req;
  apb_rsp_t    apb_rsp;
  logic        evt_valid;
  logic [2:0]  evt_chan;
  logic [7:0]  evt_code;
  logic        auto_reset_seen;
  logic        sso;
  logic        ifi;
  logic [4:0]  led;
  logic [7:0]  sta;
  logic        irq;
  logic [31:0] q;
  logic        e;
  int          n_fail;
  int          tests_run;
  int          cyc;

  relay_port #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .srst(srst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .evt_valid(evt_valid),
    .evt_chan(evt_chan), .evt_code(evt_code), .auto_reset_seen(auto_reset_seen),
    .self_sup_out(sso), .internal_fault_indicator(ifi), .led_pattern(led),
    .station_addr(sta), .irq(irq));
  remote_host i_host (.sys_clk(sys_clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, x, g);
    end
  endtask
  // one extra edge so registered outputs have landed
  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, e);
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic push(int n, logic [7:0] c0);
    for (int i = 0; i < n; i++)
    begin
      evt_valid <= 1'b1;
      evt_chan  <= 3'(i);
      evt_code  <= c0 + 8'(i);
      @(posedge sys_clk);
    end
    evt_valid <= 1'b0;
  endtask
  task automatic slot(int k, logic [10:0] x);
    rd(OFF_EVT_WIN + 8'(4 * k));
    chk("slot", {21'h0, x}, {21'h0, q[10:0]});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("addr", 32'h1, {24'h0, sta});
    rd(OFF_STATUS);
    chk("status", 32'h0, q);
    rd(8'h40);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("test reset done");
  endtask
  task automatic t_addr;
    wr(OFF_ADDR, 32'h0);
    wr(OFF_ADDR, 32'hFF);
    chk("addr kept", 32'h1, {24'h0, sta});
    wr(OFF_ADDR, 32'hFE);
    rd(OFF_ADDR);
    chk("addr", 32'hFE, q);
    $display("test addr done");
  endtask
  task automatic t_pwd;
    wr(OFF_LEDTEST, 32'h5);
    wr(OFF_PWD_OPEN, 32'h2);
    wr(OFF_LEDTEST, 32'h5);
    chk("led closed", 32'h0, {27'h0, led});
    wr(OFF_PWD_OPEN, 32'h1);
    wr(OFF_LEDTEST, 32'h1D);
    wr(OFF_LEDTEST, 32'h1C);
    chk("led", 32'h1C, {27'h0, led});
    wr(OFF_PWD_CHG, 32'h3E8);
    wr(OFF_PWD_CHG, 32'h7);
    wr(OFF_PWD_CHG, 32'h0);
    wr(OFF_LEDTEST, 32'h3);
    wr(OFF_PWD_OPEN, 32'h1);
    wr(OFF_LEDTEST, 32'h3);
    chk("led shut", 32'h1C, {27'h0, led});
    wr(OFF_PWD_OPEN, 32'h7);
    wr(OFF_LEDTEST, 32'h3);
    chk("led new pwd", 32'h3, {27'h0, led});
    $display("test password done");
  endtask
  task automatic t_sup;
    wr(OFF_SELFSUP, 32'h1);
    wr(OFF_SELFSUP, 32'h2);
    chk("fault on", 32'h3, {30'h0, sso, ifi});
    wr(OFF_SELFSUP, 32'h0);
    chk("fault off", 32'h0, {30'h0, sso, ifi});
    $display("test supervision done");
  endtask
  task automatic t_time;
    wr(OFF_TIME, 32'hEA60);
    wr(OFF_TIME, 32'hEA5F);
    rd(OFF_TIME);
    chk("time wrap", 32'h1, {31'h0, q == 32'hEA5F || q == 32'h0});
    $display("test time done");
  endtask
  task automatic t_evt;
    logic [15:0] s0;
    s0 = 16'h0000;
    push(7, 8'h10);
    wr(OFF_EVT_CMD, CMD_EVT_READ);
    rd(OFF_EVT_CNT);
    chk("count", 32'h205, q);
    for (int k = 0; k < 5; k++)
    begin
      slot(k, {3'(k), 8'h10 + 8'(k)});
      if (k == 0)
        s0 = q[26:11];
    end
    // events four cycles apart straddle exactly one millisecond tick of four cycles
    chk("stamp step", 32'h1, {16'h0, q[26:11] - s0});
    wr(OFF_EVT_CMD, CMD_EVT_REREAD);
    wr(OFF_EVT_CMD, CMD_EVT_REREAD);
    slot(4, {3'h4, 8'h14});
    wr(OFF_EVT_CMD, CMD_EVT_READ);
    rd(OFF_EVT_CNT);
    chk("count", 32'h2, q);
    slot(0, {3'h5, 8'h15});
    slot(2, 11'h0);
    $display("test events done");
  endtask
  task automatic t_ovf;
    push(61, 8'h40);
    rd(OFF_EVT_CNT);
    chk("fill", 32'h3C, {24'h0, q[15:8]});
    rd(OFF_STATUS);
    chk("status", 32'h2, q);
    auto_reset_seen <= 1'b1;
    @(posedge sys_clk);
    auto_reset_seen <= 1'b0;
    rd(OFF_STATUS);
    chk("status", 32'h3, q);
    wr(OFF_STATUS, 32'h0);
    rd(OFF_STATUS);
    chk("status", 32'h0, q);
    wr(OFF_EVT_CMD, CMD_EVT_READ);
    slot(0, {3'h0, 8'h40});
    $display("test overflow done");
  endtask
  task automatic t_irq;
    wr(OFF_IRQ_STAT, 32'hF);
    wr(OFF_ADDR, 32'h0);
    @(posedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFF_IRQ_MASK, 32'h4);
    @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_STAT, 32'h4);
    @(posedge sys_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test interrupt done");
  endtask

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      stop_test();
    end
  end
  initial
  begin
    srst = 1'b1;
    evt_valid = 1'b0;
    evt_chan = 3'h0;
    evt_code = 8'h00;
    auto_reset_seen = 1'b0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_addr();
    t_pwd();
    t_sup();
    t_time();
    t_evt();
    t_ovf();
    t_irq();
    stop_test();
  end
endmodule
